// file: shared/modem_rx_pkg.sv
/*
 * Constants for the modem receive clock and data recovery block.
 * Assumes a 20 MHz system clock and a 1 us bit time on the line.
 */
package modem_rx_pkg;

	// System clock
	localparam int CLK_PERIOD_NS = 50;

	// Interval times in their own units
	localparam int  TRANS_PULSE_NS = 200;
	localparam int  WINDOW_NS      = 750;
	localparam int  RX_CLOCK_NS    = 250;
	localparam real LOS_TIME_US    = 1.5;

	// Counter width for all one-shot intervals
	localparam int CNT_W = 5;

	// Interval lengths in clock cycles, least times rounded up
	localparam logic [CNT_W-1:0] PULSE_CYC  = CNT_W'((TRANS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WINDOW_CYC = CNT_W'((WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RXCLK_CYC  = CNT_W'((RX_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] LOS_CYC    = CNT_W'(int'($ceil(LOS_TIME_US * 1000.0 / CLK_PERIOD_NS)));

	// Counter value after reset
	localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

	// Received byte assembly and buffering
	localparam int BYTE_W     = 8;
	localparam int BIT_CNT_W  = 3;
	localparam int FIFO_DEPTH = 8;

	localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST  = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
	localparam logic [BYTE_W-1:0]    BYTE_RST     = 8'h00;

endpackage

// file: shared/byte_stream_if.sv
/*
 * Valid/ready byte stream between the recovery logic and its FIFO.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface byte_stream_if #(
	parameter int W = 8
);
	logic [W-1:0] in_data;
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] out_data;
	logic         out_valid;
	logic         out_ready;

	modport prod (
		output in_data,
		output in_valid,
		input  in_ready,
		input  out_data,
		input  out_valid,
		output out_ready
	);

	modport fifo (
		input  in_data,
		input  in_valid,
		output in_ready,
		output out_data,
		output out_valid,
		input  out_ready
	);
endinterface

// file: src/rx_byte_fifo.sv
/*
 * Synchronous FIFO for received bytes, width and depth as parameters.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module rx_byte_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	// Stream ports
	byte_stream_if.fifo bus
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr_q;
	logic [AW:0]  rd_ptr_q;
	logic         full;
	logic         empty;
	logic         do_wr;
	logic         do_rd;

	assign empty = (wr_ptr_q == rd_ptr_q);
	assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign do_wr = bus.in_valid && !full;
	assign do_rd = bus.out_ready && !empty;

	assign bus.in_ready  = !full;
	assign bus.out_valid = !empty;
	assign bus.out_data  = mem[rd_ptr_q[AW-1:0]];

	// Storage
	always_ff @(posedge clk_sys_i) begin
		if (do_wr) begin
			mem[wr_ptr_q[AW-1:0]] <= bus.in_data;
		end
	end

	// Write pointer
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_q <= '0;
		end else if (do_wr) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_ptr_q <= '0;
		end else if (do_rd) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule

// file: src/modem_rx_clock_data_recovery.sv
/*
 * Receive clock and data recovery for a transition-coded coaxial modem line.
 * Assumes the two complementary zero-crossing detector outputs arrive
 * asynchronously and the system clock oversamples the bit rate by twenty.
 */
// Overview of operation
// - Each rising detector edge gives one 200 ns pulse; both merge into one stream.
// - One pulse per bit period means a one, two pulses mean a zero.
// - Each pulse rise clocks the zero-detect flop; one outside a window starts a 750 ns window.
// - The window cannot be restarted or lengthened by pulses while active.
// - While receiving, the window spans the first three quarters of each bit.
// - Zero-detect samples the window on each pulse; set only in zero bits.
// - Received-bit flop loads zero-detect at each window start and holds one bit.
// - Recovered data output is the inverted received-bit flop.
// - No receive clock until two zeros in a row are seen.
// - Link-up stage loads zero-detect AND received-bit at each window start.
// - Clock enable loads link-up stage at next start, then holds until timeout.
// - Receive clock is inverted window gated by enable, 250 ns at bit end.
// - A 1.5 us retriggerable timer restarts at every window start.
// - Timer expiry clears zero-detect, link-up stage and clock enable.
`timescale 1ns/1ns
module modem_rx_clock_data_recovery #(
	parameter int FIFO_DEPTH = modem_rx_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                            clk_sys_i,
	input  wire logic                            nrst_i,
	// Zero-crossing detector outputs
	input  wire logic                            det_pos_i,
	input  wire logic                            det_neg_i,
	// Recovered serial data and clock
	output logic                                 recovered_data_out_o,
	output logic                                 recovered_rx_clock_o,
	output logic                                 link_up_o,
	// Buffered received bytes
	output logic [modem_rx_pkg::BYTE_W-1:0]      byte_data_o,
	output logic                                 byte_valid_o,
	input  wire logic                            byte_ready_i,
	output logic                                 overrun_o
);
	localparam int CW = modem_rx_pkg::CNT_W;

	logic [1:0]          det_in;
	logic [1:0]          sync1_q;
	logic [1:0]          sync2_q;
	logic [1:0]          sync3_q;
	logic [2:0]          arm_q;
	logic [1:0]          det_rise;
	logic [CW-1:0]       pulse_cnt_q [2];
	logic [1:0]          pulse_act;
	logic                merged;
	logic                merged_q;
	logic                trans_rise;
	logic [CW-1:0]       win_cnt_q;
	logic                sample_window_pulse;
	logic                win_start;
	logic                zero_detect_ff_q;
	logic                rx_bit_q;
	logic                linkup_stage_ff_q;
	logic                clk_en_q;
	logic                rx_clk_q;
	logic [CW-1:0]       los_cnt_q;
	logic                los_fire;
	logic                bit_tick_q;
	logic [modem_rx_pkg::BYTE_W-1:0]    shift_q;
	logic [modem_rx_pkg::BIT_CNT_W-1:0] bit_cnt_q;
	logic [modem_rx_pkg::BYTE_W-1:0]    push_data_q;
	logic                push_q;
	logic                overrun_q;
	logic [CW-1:0]       idle_cnt_q;

	byte_stream_if #(.W(modem_rx_pkg::BYTE_W)) bstream ();

	assign det_in = {det_neg_i, det_pos_i};

	// Input synchronizers and edge history, edges masked until the history holds real samples
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
			arm_q   <= 3'h0;
		end else begin
			sync1_q <= det_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			arm_q   <= {arm_q[1:0], 1'b1};
		end
	end

	assign det_rise = sync2_q & ~sync3_q & {2{arm_q[2]}};

	// One non-retriggerable pulse shaper per detector
	for (genvar i = 0; i < 2; i++) begin : g_shaper
		always_ff @(posedge clk_sys_i or negedge nrst_i) begin
			if (!nrst_i) begin
				pulse_cnt_q[i] <= modem_rx_pkg::CNT_RST;
			end else if (det_rise[i] && pulse_cnt_q[i] == modem_rx_pkg::CNT_RST) begin
				pulse_cnt_q[i] <= modem_rx_pkg::PULSE_CYC;
			end else if (pulse_cnt_q[i] != modem_rx_pkg::CNT_RST) begin
				pulse_cnt_q[i] <= pulse_cnt_q[i] - 1'b1;
			end
		end
		assign pulse_act[i] = (pulse_cnt_q[i] != modem_rx_pkg::CNT_RST);
	end

	assign merged = |pulse_act;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			merged_q <= 1'b0;
		end else begin
			merged_q <= merged;
		end
	end

	assign trans_rise = merged && !merged_q;

	// Sampling window one-shot
	assign sample_window_pulse = (win_cnt_q != modem_rx_pkg::CNT_RST);
	assign win_start           = trans_rise && !sample_window_pulse;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			win_cnt_q <= modem_rx_pkg::CNT_RST;
		end else if (win_start) begin
			win_cnt_q <= modem_rx_pkg::WINDOW_CYC;
		end else if (sample_window_pulse) begin
			win_cnt_q <= win_cnt_q - 1'b1;
		end
	end

	// Zero-detect flop, a new pulse wins over the timeout clear
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			zero_detect_ff_q <= 1'b0;
		end else if (trans_rise) begin
			zero_detect_ff_q <= sample_window_pulse;
		end else if (los_fire) begin
			zero_detect_ff_q <= 1'b0;
		end
	end

	// Received-bit flop
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_bit_q <= 1'b0;
		end else if (win_start) begin
			rx_bit_q <= zero_detect_ff_q;
		end
	end

	assign recovered_data_out_o = !rx_bit_q;

	// Link-up stage flop
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			linkup_stage_ff_q <= 1'b0;
		end else if (win_start) begin
			linkup_stage_ff_q <= zero_detect_ff_q && rx_bit_q;
		end else if (los_fire) begin
			linkup_stage_ff_q <= 1'b0;
		end
	end

	// Clock-enable latch, holds itself once set
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_en_q <= 1'b0;
		end else if (win_start && linkup_stage_ff_q) begin
			clk_en_q <= 1'b1;
		end else if (los_fire) begin
			clk_en_q <= 1'b0;
		end
	end

	assign link_up_o = clk_en_q;

	// Receive clock
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_clk_q <= 1'b0;
		end else begin
			rx_clk_q <= clk_en_q && !sample_window_pulse;
		end
	end

	assign recovered_rx_clock_o = rx_clk_q;

	// Retriggerable loss-of-signal timer
	assign los_fire = (los_cnt_q == 5'h01) && !win_start;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			los_cnt_q <= modem_rx_pkg::CNT_RST;
		end else if (win_start) begin
			los_cnt_q <= modem_rx_pkg::LOS_CYC;
		end else if (los_cnt_q != modem_rx_pkg::CNT_RST) begin
			los_cnt_q <= los_cnt_q - 1'b1;
		end
	end

	// Bit tick one cycle after each window start
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bit_tick_q <= 1'b0;
		end else begin
			bit_tick_q <= win_start;
		end
	end

	// Byte assembly, least significant bit first, only while clocked
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_q   <= modem_rx_pkg::BYTE_RST;
			bit_cnt_q <= modem_rx_pkg::BIT_CNT_RST;
		end else if (!clk_en_q) begin
			bit_cnt_q <= modem_rx_pkg::BIT_CNT_RST;
		end else if (bit_tick_q) begin
			shift_q   <= {recovered_data_out_o, shift_q[modem_rx_pkg::BYTE_W-1:1]};
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// Byte push into the FIFO
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			push_q      <= 1'b0;
			push_data_q <= modem_rx_pkg::BYTE_RST;
		end else if (clk_en_q && bit_tick_q && bit_cnt_q == modem_rx_pkg::BIT_CNT_LAST) begin
			push_q      <= 1'b1;
			push_data_q <= {recovered_data_out_o, shift_q[modem_rx_pkg::BYTE_W-1:1]};
		end else begin
			push_q <= 1'b0;
		end
	end

	// Overrun when a byte meets a full FIFO, cleared on link loss
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			overrun_q <= 1'b0;
		end else if (push_q && !bstream.in_ready) begin
			overrun_q <= 1'b1;
		end else if (los_fire) begin
			overrun_q <= 1'b0;
		end
	end

	assign overrun_o         = overrun_q;
	assign bstream.in_data   = push_data_q;
	assign bstream.in_valid  = push_q;
	assign bstream.out_ready = byte_ready_i;
	assign byte_data_o       = bstream.out_data;
	assign byte_valid_o      = bstream.out_valid;

	rx_byte_fifo #(
		.W     (modem_rx_pkg::BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.bus       (bstream)
	);

	// Cycles since the last window start, for checking only
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idle_cnt_q <= modem_rx_pkg::CNT_RST;
		end else if (win_start) begin
			idle_cnt_q <= modem_rx_pkg::CNT_RST;
		end else if (idle_cnt_q != 5'h1f) begin
			idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end

	// Checks
	property p_pulse_len;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(pulse_act[0]) |-> pulse_act[0][*4] ##1 !pulse_act[0];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("Detector pulse not 200 ns");

	property p_merge;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		det_rise[1] && !pulse_act[1] |=> (merged && pulse_act[1]) [*4] ##1 !pulse_act[1];
	endproperty
	a_merge: assert property (p_merge) else $error("Pulse streams not merged");

	property p_window_len;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(sample_window_pulse) |-> ##14 sample_window_pulse ##1 !sample_window_pulse;
	endproperty
	a_window_len: assert property (p_window_len) else $error("Window not 750 ns");

	property p_no_retrigger;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		trans_rise && sample_window_pulse |=> win_cnt_q == $past(win_cnt_q) - 5'h01;
	endproperty
	a_no_retrigger: assert property (p_no_retrigger) else $error("Window restarted while active");

	property p_zero_detect;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		trans_rise |=> zero_detect_ff_q == $past(sample_window_pulse);
	endproperty
	a_zero_detect: assert property (p_zero_detect) else $error("Zero-detect sampled wrongly");

	property p_rx_bit;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		win_start && zero_detect_ff_q |=> !recovered_data_out_o;
	endproperty
	a_rx_bit: assert property (p_rx_bit) else $error("Zero bit not driven low");

	property p_stage;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		win_start |=> linkup_stage_ff_q == $past(zero_detect_ff_q && rx_bit_q);
	endproperty
	a_stage: assert property (p_stage) else $error("Link-up stage loaded wrongly");

	property p_enable_cause;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(clk_en_q) |-> $past(linkup_stage_ff_q) && $past(win_start);
	endproperty
	a_enable_cause: assert property (p_enable_cause) else $error("Clock enabled without link-up");

	property p_enable_hold;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		clk_en_q && !los_fire |=> clk_en_q;
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("Clock enable dropped early");

	property p_rx_clock;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		recovered_rx_clock_o |-> $past(clk_en_q) && !$past(sample_window_pulse);
	endproperty
	a_rx_clock: assert property (p_rx_clock) else $error("Receive clock not gated");

	property p_los_time;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		los_fire |-> idle_cnt_q == 5'h1d;
	endproperty
	a_los_time: assert property (p_los_time) else $error("Timeout not 1.5 us after last start");

	property p_los_clear;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		los_fire && !trans_rise |=> !zero_detect_ff_q && !linkup_stage_ff_q && !clk_en_q;
	endproperty
	a_los_clear: assert property (p_los_clear) else $error("Timeout did not clear link-up");
endmodule

// file: tb/modem_tx_model.sv
/*
 * Remote transmitter model: drives the two complementary detector outputs
 * as a transition-coded line with a 1 us bit time.
 * Assumes its own time base, unrelated in phase to the system clock.
 */
`timescale 1ns/1ns
module modem_tx_model (
	// Detector outputs towards the receiver
	output logic det_pos_o,
	output logic det_neg_o
);
	logic line_q;

	initial line_q = 1'b0;

	// Complementary detectors, one rises on each line transition
	assign det_pos_o = line_q;
	assign det_neg_o = ~line_q;

	// One transition at bit start, a second at mid bit for a zero
	task automatic send_bit(input logic bit_v);
		line_q = ~line_q;
		#500;
		if (!bit_v) line_q = ~line_q;
		#500;
	endtask
endmodule

// file: tb/modem_rx_clock_data_recovery_tb_top.sv
/*
 * Self-checking bench for the receive clock and data recovery block.
 * Assumes the transmitter model on the line and a random-stall byte consumer.
 */
`timescale 1ns/1ns
module modem_rx_clock_data_recovery_tb_top;
	logic                              clk_sys_i;
	logic                              nrst_i;
	logic                              det_pos;
	logic                              det_neg;
	logic                              byte_ready_i;
	logic                              recovered_data_out_o;
	logic                              recovered_rx_clock_o;
	logic                              link_up_o;
	logic                              byte_valid_o;
	logic                              overrun_o;
	logic [modem_rx_pkg::BYTE_W-1:0]   byte_data_o;
	logic                              rxclk_d;
	logic                              hold_link;
	logic                              prev_bit;
	logic [7:0]                        exp_q[$];
	int                                errors;
	int                                checked;
	int                                seed;
	int                                clk_rises;
	int                                ready_en;

	modem_rx_clock_data_recovery modem_rx_clock_data_recovery_i (
		.clk_sys_i            (clk_sys_i),
		.nrst_i               (nrst_i),
		.det_pos_i            (det_pos),
		.det_neg_i            (det_neg),
		.recovered_data_out_o (recovered_data_out_o),
		.recovered_rx_clock_o (recovered_rx_clock_o),
		.link_up_o            (link_up_o),
		.byte_data_o          (byte_data_o),
		.byte_valid_o         (byte_valid_o),
		.byte_ready_i         (byte_ready_i),
		.overrun_o            (overrun_o)
	);

	modem_tx_model modem_tx_model_i (
		.det_pos_o (det_pos),
		.det_neg_o (det_neg)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	function automatic int exp_cycles(input int ns);
		return (ns + 49) / 50;
	endfunction

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Consumer with random stalls
	always @(negedge clk_sys_i) begin
		byte_ready_i <= (ready_en != 0) && ($random(seed) % 2 == 0);
	end

	// Byte pops, receive clock rises and link hold
	always @(posedge clk_sys_i) begin
		rxclk_d <= recovered_rx_clock_o;
		if (recovered_rx_clock_o === 1'b1 && rxclk_d === 1'b0) clk_rises++;
		if (hold_link && link_up_o !== 1'b1) check("link held", 8'h01, 8'h00);
		if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected byte", 8'h00, 8'hff);
			else check("byte", exp_q.pop_front(), byte_data_o);
		end
	end

	// Send one bit and check the bit before it mid-way
	task automatic send_chk(input logic bit_v);
		fork
			modem_tx_model_i.send_bit(bit_v);
			begin
				#700;
				check("recovered data", {7'h00, prev_bit}, {7'h00, recovered_data_out_o});
			end
		join
		prev_bit = bit_v;
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) send_chk(b[i]);
	endtask

	task automatic pulse_width(output int n);
		n = 0;
		@(posedge recovered_rx_clock_o);
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (recovered_rx_clock_o === 1'b1);
	endtask

	// Link-up, data bytes, one trailing one, then silence
	task automatic run_link(input int nbytes, input int stall);
		logic [7:0] b;
		int         w;
		clk_rises = 0;
		ready_en = (stall == 0);
		for (int i = 0; i < 6; i++) send_chk(i > 3 ? 1'b0 : 1'b1);
		check("valid before clock", 8'h00, {7'h00, byte_valid_o});
		check("clock before link-up", 8'h00, 8'(clk_rises));
		for (int k = 0; k < nbytes; k++) begin
			b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
			if (k < 8 || stall == 0) exp_q.push_back(b);
			if (k == 0) begin
				fork
					send_byte(b);
					pulse_width(w);
				join
				check("clock pulse width", 8'(exp_cycles(250)), 8'(w));
				hold_link = 1'b1;
			end else begin
				send_byte(b);
			end
		end
		send_chk(1'b1);
		hold_link = 1'b0;
		check("overrun flag", 8'(stall), {7'h00, overrun_o});
		ready_en = 1;
		#2500;
		check("link after silence", 8'h00, {7'h00, link_up_o});
		check("clock after silence", 8'h00, {7'h00, recovered_rx_clock_o});
		check("clock count", 8'(8 * nbytes), 8'(clk_rises));
		check("bytes left", 8'h00, 8'(exp_q.size()));
		check("overrun after silence", 8'h00, {7'h00, overrun_o});
	endtask

	initial begin
		errors = 0;
		checked = 0;
		seed = 13889;
		ready_en = 0;
		hold_link = 1'b0;
		prev_bit = 1'b1;
		clk_rises = 0;
		rxclk_d = 1'b0;
		byte_ready_i = 1'b0;
		nrst_i = 1'b0;
		repeat (12) @(negedge clk_sys_i);
		check("reset outputs", 8'h10, {3'h0, recovered_data_out_o, recovered_rx_clock_o, link_up_o,
			byte_valid_o, overrun_o});
		nrst_i = 1'b1;
		#37;
		// Preamble missing its second zero
		for (int i = 0; i < 7; i++) send_chk(i != 4);
		#2500;
		check("clock without preamble", 8'h00, 8'(clk_rises));
		check("link without preamble", 8'h00, {7'h00, link_up_o});
		run_link(3, 0);
		// Fill the buffer until it refuses, then drain it
		run_link(10, 1);
		close_out();
	end

	initial begin
		#1000000;
		errors++;
		close_out();
	end
endmodule
